// ==== include/acfg_defines.vh ====
// constants of the two-wire configuration slave
`ifndef ACFG_DEFINES_VH
`define ACFG_DEFINES_VH

// bus addressing
`define ACFG_SLAVE_ADDR 7'h36
`define ACFG_HS_CODE_TOP 5'h01

// byte type flag and field positions
`define ACFG_REG_BIT 7
`define ACFG_SET_REF_HI 6
`define ACFG_SET_REF_LO 4
`define ACFG_SET_CLK_BIT 3
`define ACFG_SET_POL_BIT 2
`define ACFG_SET_RST_BIT 1
`define ACFG_CFG_SCAN_HI 6
`define ACFG_CFG_SCAN_LO 5
`define ACFG_CFG_CS_BIT 1
`define ACFG_CFG_SGL_BIT 0

// reset values
`define ACFG_SETUP_RST 8'h80
`define ACFG_CONFIG_RST 8'h01

// byte buffer shape
`define ACFG_FIFO_WIDTH 8
`define ACFG_FIFO_DEPTH 8
`define ACFG_FIFO_AW 3

// result code limits
`define ACFG_UNI_MAX 11'h3FF
`define ACFG_BIP_MAX 11'h1FF
`define ACFG_BIP_MIN 11'h600
`define ACFG_BIP_CODE_MAX 10'h1FF
`define ACFG_BIP_CODE_MIN 10'h200

`endif

// ==== src/acfg_fifo.v ====
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
module acfg_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire sys_clk_in,
    input wire rst_in,
    // fill side
    input wire in_valid_in,
    input wire [WIDTH-1:0] in_data_in,
    output wire in_ready_out,
    // drain side
    output wire out_valid_out,
    output wire [WIDTH-1:0] out_data_out,
    input wire out_ready_in
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;
    wire push;
    wire pop;

    assign in_ready_out = (count_r != DEPTH[AW:0]);
    assign out_valid_out = (count_r != {(AW+1){1'b0}});
    assign out_data_out = mem_r[rd_ptr_r];
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;

    always @(posedge sys_clk_in) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_in;
        end
    end

    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
            end
            if (push & ~pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop & ~push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule

// ==== src/acfg_slave.v ====
// two-wire configuration slave with setup/config bytes and result coding
//
// Operation
// - single-ended: selected channel against ground
// - differential: pair chosen by channel select
// - unipolar differential negative input gives zero
// - straight binary unipolar, two's complement bipolar
// - single-ended always uses unipolar coding
// - one bit per clock, byte transfer needs 9
// - data changes only while clock low
// - detect start and stop conditions
// - repeated start keeps bus and timing mode
// - acknowledge: data low through ninth pulse
// - not-acknowledge: data released on ninth pulse
// - respond only to own seven-bit address
// - address last bit gives transfer direction
// - acknowledge matching address for one clock
// - power-up standard/fast timing; master code selects high-speed
// - not-acknowledge master code, then high-speed timing
// - stop returns to standard/fast timing
// - top bit picks setup or configuration byte
// - one or more bytes, each acknowledged while the buffer has room
// - polarity select: 1 bipolar, reset 0
// - setup reset bit 0 restores configuration byte
`timescale 1ns/1ns
`include "acfg_defines.vh"
module acfg_slave (
    // clock and reset
    input wire sys_clk_in,
    input wire rst_in,
    // two-wire pins
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe_out,
    // converter side hold of byte application
    input wire cfg_freeze_in,
    // setup fields
    output wire [2:0] ref_select_out,
    output wire ext_clock_out,
    output wire polarity_select_out,
    // configuration fields
    output wire [1:0] scan_select_out,
    output wire channel_select_out,
    output wire input_mode_select_out,
    // input multiplexer steering
    output wire [1:0] mux_pos_out,
    output wire [1:0] mux_neg_out,
    output wire mux_neg_gnd_out,
    // bus status
    output wire hs_mode_out,
    output wire bus_busy_out,
    output wire read_req_out,
    // result coding
    input wire sample_valid_in,
    input wire [10:0] sample_in,
    output wire result_valid_out,
    output wire [9:0] result_code_out
);
    localparam ST_IDLE = 6'h01;
    localparam ST_ADDR = 6'h02;
    localparam ST_ACK = 6'h04;
    localparam ST_DATA = 6'h08;
    localparam ST_SKIP = 6'h10;
    localparam ST_WAIT = 6'h20;

    // pin synchronisers and edge history
    reg scl_s1_r;
    reg scl_s2_r;
    reg scl_s3_r;
    reg sda_s1_r;
    reg sda_s2_r;
    reg sda_s3_r;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;

    // protocol state
    reg [5:0] state_r;
    reg [5:0] after_ack_r;
    reg [3:0] bit_cnt_r;
    reg [7:0] shift_r;
    reg sda_oe_r;
    reg sda_level_r;
    reg hs_mode_r;
    reg busy_r;
    reg read_req_r;
    reg push_r;
    reg [7:0] push_data_r;

    // control bytes
    reg [7:0] setup_r;
    reg [7:0] config_r;
    reg [1:0] mux_pos_r;
    reg [1:0] mux_neg_r;
    reg mux_neg_gnd_r;

    // result path
    reg result_valid_r;
    reg [9:0] result_r;
    reg [9:0] code_nxt;
    reg bipolar_nxt;

    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire [7:0] rx_byte;
    wire apply;

    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_s3_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_s3_r <= 1'b1;
        end else begin
            scl_s1_r <= scl_in;
            scl_s2_r <= scl_s1_r;
            scl_s3_r <= scl_s2_r;
            sda_s1_r <= sda_in;
            sda_s2_r <= sda_s1_r;
            sda_s3_r <= sda_s2_r;
        end
    end

    assign scl_rise = scl_s2_r & ~scl_s3_r;
    assign scl_fall = ~scl_s2_r & scl_s3_r;
    // data moving while the clock stays high is a bus condition
    assign start_det = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
    assign stop_det = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;
    assign rx_byte = shift_r;

    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            state_r <= ST_IDLE;
            after_ack_r <= ST_SKIP;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            sda_oe_r <= 1'b0;
            sda_level_r <= 1'b0;
            hs_mode_r <= 1'b0;
            busy_r <= 1'b0;
            read_req_r <= 1'b0;
            push_r <= 1'b0;
            push_data_r <= 8'h00;
        end else begin
            sda_level_r <= 1'b0;
            read_req_r <= 1'b0;
            push_r <= 1'b0;
            if (stop_det) begin
                state_r <= ST_IDLE;
                sda_oe_r <= 1'b0;
                busy_r <= 1'b0;
                hs_mode_r <= 1'b0;
            end else if (start_det) begin
                // a restart keeps the timing mode
                state_r <= ST_ADDR;
                bit_cnt_r <= 4'h0;
                sda_oe_r <= 1'b0;
                busy_r <= 1'b1;
            end else begin
                case (state_r)
                    ST_ADDR, ST_DATA: begin
                        if (scl_rise && bit_cnt_r != 4'h8) begin
                            shift_r <= {shift_r[6:0], sda_s2_r};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (scl_fall && bit_cnt_r == 4'h8) begin
                            bit_cnt_r <= 4'h0;
                            state_r <= ST_ACK;
                            if (state_r == ST_ADDR) begin
                                if (rx_byte[7:1] == `ACFG_SLAVE_ADDR) begin
                                    sda_oe_r <= 1'b1;
                                    read_req_r <= rx_byte[0];
                                    after_ack_r <= rx_byte[0] ? ST_SKIP : ST_DATA;
                                end else if (rx_byte[7:3] == `ACFG_HS_CODE_TOP) begin
                                    // released line is the not-acknowledge
                                    sda_oe_r <= 1'b0;
                                    hs_mode_r <= 1'b1;
                                    after_ack_r <= ST_WAIT;
                                end else begin
                                    sda_oe_r <= 1'b0;
                                    after_ack_r <= ST_SKIP;
                                    state_r <= ST_SKIP;
                                end
                            end else if (fifo_in_ready) begin
                                // full buffer refuses the byte with a not-acknowledge
                                sda_oe_r <= 1'b1;
                                push_r <= 1'b1;
                                push_data_r <= rx_byte;
                                after_ack_r <= ST_DATA;
                            end else begin
                                sda_oe_r <= 1'b0;
                                after_ack_r <= ST_SKIP;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            // release right after the ninth pulse
                            sda_oe_r <= 1'b0;
                            state_r <= after_ack_r;
                        end
                    end
                    ST_SKIP, ST_WAIT, ST_IDLE: begin
                        sda_oe_r <= 1'b0;
                    end
                    default: begin
                        state_r <= ST_IDLE;
                        sda_oe_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    acfg_fifo #(
        .WIDTH(`ACFG_FIFO_WIDTH),
        .DEPTH(`ACFG_FIFO_DEPTH),
        .AW(`ACFG_FIFO_AW)
    ) u_fifo (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .in_valid_in(push_r),
        .in_data_in(push_data_r),
        .in_ready_out(fifo_in_ready),
        .out_valid_out(fifo_out_valid),
        .out_data_out(fifo_out_data),
        .out_ready_in(~cfg_freeze_in)
    );

    // bytes wait while the converter freezes its settings
    assign apply = fifo_out_valid & ~cfg_freeze_in;

    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            setup_r <= `ACFG_SETUP_RST;
            config_r <= `ACFG_CONFIG_RST;
        end else if (apply) begin
            if (fifo_out_data[`ACFG_REG_BIT]) begin
                setup_r <= fifo_out_data;
                if (!fifo_out_data[`ACFG_SET_RST_BIT]) begin
                    config_r <= `ACFG_CONFIG_RST;
                end
            end else begin
                config_r <= fifo_out_data;
            end
        end
    end

    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            mux_pos_r <= 2'h1;
            mux_neg_r <= 2'h0;
            mux_neg_gnd_r <= 1'b1;
        end else begin
            mux_pos_r <= config_r[`ACFG_CFG_CS_BIT] ? 2'h2 : 2'h1;
            if (config_r[`ACFG_CFG_SGL_BIT]) begin
                mux_neg_r <= 2'h0;
                mux_neg_gnd_r <= 1'b1;
            end else begin
                mux_neg_r <= config_r[`ACFG_CFG_CS_BIT] ? 2'h1 : 2'h2;
                mux_neg_gnd_r <= 1'b0;
            end
        end
    end

    // sample is the signed difference in code steps
    always @* begin
        bipolar_nxt = setup_r[`ACFG_SET_POL_BIT] & ~config_r[`ACFG_CFG_SGL_BIT];
        code_nxt = 10'h000;
        if (bipolar_nxt) begin
            if (!sample_in[10] && sample_in > `ACFG_BIP_MAX) begin
                code_nxt = `ACFG_BIP_CODE_MAX;
            end else if (sample_in[10] && sample_in < `ACFG_BIP_MIN) begin
                code_nxt = `ACFG_BIP_CODE_MIN;
            end else begin
                code_nxt = sample_in[9:0];
            end
        end else if (sample_in[10]) begin
            code_nxt = 10'h000;
        end else begin
            code_nxt = sample_in[9:0];
        end
    end

    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            result_valid_r <= 1'b0;
            result_r <= 10'h000;
        end else begin
            result_valid_r <= sample_valid_in;
            if (sample_valid_in) begin
                result_r <= code_nxt;
            end
        end
    end

    assign sda_out = sda_level_r;
    assign sda_oe_out = sda_oe_r;
    assign ref_select_out = setup_r[`ACFG_SET_REF_HI:`ACFG_SET_REF_LO];
    assign ext_clock_out = setup_r[`ACFG_SET_CLK_BIT];
    assign polarity_select_out = setup_r[`ACFG_SET_POL_BIT];
    assign scan_select_out = config_r[`ACFG_CFG_SCAN_HI:`ACFG_CFG_SCAN_LO];
    assign channel_select_out = config_r[`ACFG_CFG_CS_BIT];
    assign input_mode_select_out = config_r[`ACFG_CFG_SGL_BIT];
    assign mux_pos_out = mux_pos_r;
    assign mux_neg_out = mux_neg_r;
    assign mux_neg_gnd_out = mux_neg_gnd_r;
    assign hs_mode_out = hs_mode_r;
    assign bus_busy_out = busy_r;
    assign read_req_out = read_req_r;
    assign result_valid_out = result_valid_r;
    assign result_code_out = result_r;
endmodule

// ==== tb/acfg_master_model.sv ====
// bit-level two-wire bus master, 400 ns bus period
`timescale 1ns/1ns
module acfg_master_model (
    // bus lines
    output reg scl_out,
    output reg sda_low_out,
    input wire sda_in
);
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // also serves as repeated start: releases the line first
    task start;
        begin
            sda_low_out = 1'b0;
            #100 scl_out = 1'b1;
            #100 sda_low_out = 1'b1;
            #100 scl_out = 1'b0;
            #100;
        end
    endtask
    task stop;
        begin
            sda_low_out = 1'b1;
            #100 scl_out = 1'b1;
            #100 sda_low_out = 1'b0;
            #100;
        end
    endtask
    task put_byte(input [7:0] b, output ack);
        integer k;
        begin
            for (k = 7; k >= 0; k = k - 1) begin
                sda_low_out = ~b[k];
                #100 scl_out = 1'b1;
                #200 scl_out = 1'b0;
                #100;
            end
            sda_low_out = 1'b0;
            #100 scl_out = 1'b1;
            #100 ack = ~sda_in;
            #100 scl_out = 1'b0;
            #100;
        end
    endtask
endmodule

// ==== tb/acfg_slave_chk.sv ====
// port assertions of the configuration slave
`timescale 1ns/1ns
module acfg_slave_chk (
    // clock and reset
    input wire sys_clk_in,
    input wire rst_in,
    // bus pins
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe_out,
    input wire hs_mode_out,
    input wire bus_busy_out,
    // fields and steering
    input wire polarity_select_out,
    input wire channel_select_out,
    input wire input_mode_select_out,
    input wire [1:0] mux_pos_out,
    input wire [1:0] mux_neg_out,
    input wire mux_neg_gnd_out,
    // result path
    input wire sample_valid_in,
    input wire [10:0] sample_in,
    input wire result_valid_out,
    input wire [9:0] result_code_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    property p_open_drain; sda_oe_out |-> sda_out == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
    property p_ack_edge; $changed(sda_oe_out) |-> !scl_in; endproperty
    a_ack_edge: assert property (p_ack_edge) else $error("data moved with clock high");
    property p_ack_hold; $rose(sda_oe_out) |-> sda_oe_out [*6]; endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ack too short");
    property p_start; scl_in && $fell(sda_in) |-> ##[1:6] bus_busy_out; endproperty
    a_start: assert property (p_start) else $error("start not seen");
    property p_stop; scl_in && $rose(sda_in) |-> ##[1:6] (!hs_mode_out && !bus_busy_out); endproperty
    a_stop: assert property (p_stop) else $error("stop not seen");
    property p_res_lat; result_valid_out == $past(sample_valid_in); endproperty
    a_res_lat: assert property (p_res_lat) else $error("result strobe late");
    property p_uni_neg; sample_valid_in && sample_in[10]
        && !(polarity_select_out && !input_mode_select_out) |=> result_code_out == 10'h000; endproperty
    a_uni_neg: assert property (p_uni_neg) else $error("negative not zero");
    property p_mux; $stable({input_mode_select_out, channel_select_out})
        |-> {mux_pos_out, mux_neg_out, mux_neg_gnd_out} == (input_mode_select_out
        ? {channel_select_out ? 2'b10 : 2'b01, 3'b001}
        : (channel_select_out ? 5'b10010 : 5'b01100)); endproperty
    a_mux: assert property (p_mux) else $error("mux steering wrong");
endmodule
bind acfg_slave acfg_slave_chk acfg_slave_chk_i (.sys_clk_in, .rst_in, .scl_in, .sda_in,
    .sda_out, .sda_oe_out, .hs_mode_out, .bus_busy_out, .polarity_select_out,
    .channel_select_out, .input_mode_select_out, .mux_pos_out, .mux_neg_out,
    .mux_neg_gnd_out, .sample_valid_in, .sample_in, .result_valid_out, .result_code_out);

// ==== tb/acfg_slave_bench.sv ====
// self-checking bench of the two-wire configuration slave
`timescale 1ns/1ns
module acfg_slave_bench;
    reg sys_clk_in = 1'b0;
    reg rst_in = 1'b1;
    reg cfg_freeze_in = 1'b0;
    reg sample_valid_in = 1'b0;
    reg [10:0] sample_in = 11'h000;
    wire scl_in, sda_in, m_low, sda_out, sda_oe_out, ext_clock_out, polarity_select_out;
    wire channel_select_out, input_mode_select_out, mux_neg_gnd_out, hs_mode_out;
    wire bus_busy_out, read_req_out, result_valid_out;
    wire [2:0] ref_select_out;
    wire [1:0] scan_select_out, mux_pos_out, mux_neg_out;
    wire [9:0] result_code_out;
    integer n_fail = 0, check_count = 0, reads = 0, i, j, k;
    reg [31:0] rng = 32'h00008BC4;
    reg [7:0] cb, sb;
    reg ack;
    // pull-up wins unless a party pulls low
    assign sda_in = (sda_oe_out ? sda_out : 1'b1) & ~m_low;
    acfg_master_model acfg_master_model_i (.scl_out(scl_in), .sda_low_out(m_low), .sda_in);
    acfg_slave acfg_slave_i (.sys_clk_in, .rst_in, .scl_in, .sda_in, .sda_out, .sda_oe_out,
        .cfg_freeze_in, .ref_select_out, .ext_clock_out, .polarity_select_out,
        .scan_select_out, .channel_select_out, .input_mode_select_out, .mux_pos_out,
        .mux_neg_out, .mux_neg_gnd_out, .hs_mode_out, .bus_busy_out, .read_req_out,
        .sample_valid_in, .sample_in, .result_valid_out, .result_code_out);
    initial forever #25 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) if (read_req_out === 1'b1) reads <= reads + 1;
    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction
    function [4:0] mux_exp(input m, input c);
        mux_exp = m ? {c ? 2'b10 : 2'b01, 3'b001} : (c ? 5'b10010 : 5'b01100);
    endfunction
    function [9:0] res_exp(input [10:0] s, input bip);
        if (bip)
            res_exp = ($signed(s) < -512) ? 10'h200 : ($signed(s) > 511) ? 10'h1FF : s[9:0];
        else
            res_exp = s[10] ? 10'h000 : s[9:0];
    endfunction
    task final_report;
        begin
            $display("checks %0d mismatches %0d", check_count, n_fail);
            if (n_fail == 0 && check_count > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input string what, input [15:0] exp, input [15:0] got);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("wrong value %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task wr(input [7:0] b, input exp_ack);
        begin
            acfg_master_model_i.put_byte(b, ack);
            chk("ack", exp_ack, ack);
        end
    endtask
    // stop, then a bounded wait for the bus to go idle
    task fin;
        begin
            acfg_master_model_i.stop;
            for (k = 0; k < 20 && bus_busy_out !== 1'b0; k = k + 1) @(negedge sys_clk_in);
            chk("busy", 1'b0, bus_busy_out);
            if (bus_busy_out !== 1'b0) final_report;
            repeat (4) @(negedge sys_clk_in);
        end
    endtask
    initial begin
        repeat (40000) @(posedge sys_clk_in);
        n_fail = n_fail + 1;
        final_report;
    end
    initial begin
        repeat (3) @(posedge sys_clk_in);
        @(negedge sys_clk_in) rst_in = 1'b0;
        chk("setup", 5'h00, {ref_select_out, ext_clock_out, polarity_select_out});
        chk("config", 4'h1, {scan_select_out, channel_select_out, input_mode_select_out});
        chk("mux", 5'h09, {mux_pos_out, mux_neg_out, mux_neg_gnd_out});
        chk("speed", 1'b0, hs_mode_out);
        acfg_master_model_i.start;
        wr(8'h6E, 1'b0);
        fin;
        for (i = 0; i < 6; i = i + 1) begin
            rng = xs(rng);
            cb = {1'b0, rng[6:0]};
            sb = {1'b1, rng[14:10], 1'b1, rng[8]};
            acfg_master_model_i.start;
            wr(8'h6C, 1'b1);
            wr(i[0] ? sb : cb, 1'b1);
            wr(i[0] ? cb : sb, 1'b1);
            fin;
            chk("setup", sb[6:2], {ref_select_out, ext_clock_out, polarity_select_out});
            chk("config", {cb[6:5], cb[1:0]},
                {scan_select_out, channel_select_out, input_mode_select_out});
            chk("mux", mux_exp(cb[0], cb[1]), {mux_pos_out, mux_neg_out, mux_neg_gnd_out});
            for (j = 0; j < 4; j = j + 1) begin
                @(negedge sys_clk_in);
                rng = xs(rng);
                sample_in = (j == 0) ? 11'h400 : (j == 1) ? 11'h3FF : rng[10:0];
                sample_valid_in = 1'b1;
                @(negedge sys_clk_in) sample_valid_in = 1'b0;
                chk("valid", 1'b1, result_valid_out);
                chk("code", res_exp(sample_in, sb[2] & ~cb[0]), result_code_out);
            end
        end
        acfg_master_model_i.start;
        wr(8'h6C, 1'b1);
        wr(8'h62, 1'b1);
        wr(8'h84, 1'b1);
        fin;
        chk("config", 4'h1, {scan_select_out, channel_select_out, input_mode_select_out});
        chk("setup", 5'h01, {ref_select_out, ext_clock_out, polarity_select_out});
        rng = xs(rng);
        acfg_master_model_i.start;
        wr({5'h01, rng[2:0]}, 1'b0);
        chk("speed", 1'b1, hs_mode_out);
        acfg_master_model_i.start;
        wr(8'h6C, 1'b1);
        wr(8'h00, 1'b1);
        chk("speed", 1'b1, hs_mode_out);
        fin;
        chk("speed", 1'b0, hs_mode_out);
        acfg_master_model_i.start;
        wr(8'h6D, 1'b1);
        fin;
        chk("reads", 16'h0001, reads);
        cfg_freeze_in = 1'b1;
        acfg_master_model_i.start;
        wr(8'h6C, 1'b1);
        for (i = 0; i < 9; i = i + 1)
            wr((i == 7) ? 8'h02 : (i == 8) ? 8'h01 : 8'h60, i < 8);
        fin;
        chk("config", 4'h0, {scan_select_out, channel_select_out, input_mode_select_out});
        cfg_freeze_in = 1'b0;
        repeat (40) @(negedge sys_clk_in);
        chk("config", 4'h2, {scan_select_out, channel_select_out, input_mode_select_out});
        acfg_master_model_i.start;
        wr(8'h6C, 1'b1);
        wr(8'h01, 1'b1);
        fin;
        chk("config", 4'h1, {scan_select_out, channel_select_out, input_mode_select_out});
        final_report;
    end
endmodule
